// [core/scp_pkg.sv]
// shared constants and types for the serial register port, both ends
package scp_pkg;

	// ***********************
	// header codes
	// ***********************
	localparam logic [7:0] HDR_CODEC_NI  = 8'h00;
	localparam logic [7:0] HDR_CODEC_IL  = 8'h08;
	localparam logic [7:0] HDR_ADAD_NI   = 8'h40;
	localparam logic [7:0] HDR_ADAD_NI_C = 8'h44;
	localparam logic [7:0] HDR_ADAD_IL   = 8'h48;
	localparam logic [7:0] HDR_ADAD_IL_C = 8'h4c;
	localparam logic [7:0] HDR_AUTO      = 8'h4a;
	localparam logic [7:0] HDR_AUTO_C    = 8'h4e;
	localparam logic [7:0] HDR_FIFO      = 8'h43;
	localparam logic [7:0] HDR_RDWR_NI   = 8'h41;
	localparam logic [7:0] HDR_RDWR_IL   = 8'h49;

	// ***********************
	// address byte layout
	// ***********************
	localparam int ADDR_RD_BIT = 7;              // set: read access
	localparam logic COEF_BASE_BIT = 1'b1;       // top address bit in coefficient range

	// codec command data counts, picked by command bits 1:0
	localparam logic [3:0] CMD_LEN0 = 4'h0;
	localparam logic [3:0] CMD_LEN1 = 4'h1;
	localparam logic [3:0] CMD_LEN2 = 4'h4;
	localparam logic [3:0] CMD_LEN3 = 4'h8;

	// ***********************
	// timing
	// ***********************
	localparam int SYS_PERIOD_NS  = 20;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
	localparam int BYTE_BITS      = 8;

	// interface chosen by the straps at reset release
	typedef enum logic [1:0] {
		MODE_SERIAL,
		MODE_MONITOR,
		MODE_PARALLEL
	} host_mode_t;

endpackage : scp_pkg

// [core/scp_if.sv]
// four-wire serial register port between host and device
`timescale 1ns/1ns
interface scp_if;
	logic sclk;
	logic select_n;
	logic serial_data_in;
	logic serial_data_out_o;
	logic serial_data_out_oe;
	logic serial_data_out;

	// undriven line floats high through the board pull-up
	assign serial_data_out = serial_data_out_oe ? serial_data_out_o : 1'b1;

	modport device (
		input  sclk,
		input  select_n,
		input  serial_data_in,
		output serial_data_out_o,
		output serial_data_out_oe
	);

	modport host (
		output sclk,
		output select_n,
		output serial_data_in,
		input  serial_data_out
	);
endinterface : scp_if

// [core/scp_device.sv]
// device end: strap decode and serial register access sequencer
`timescale 1ns/1ns
// What this block does
// - sample strap pins once at reset release
// - small package: select high serial, low monitor
// - large package: both strobes high pick parallel, else select decides
// - no host: program registers via monitor channel
// - board ties unused strap pins static
// - four lines: clock, data out, in, select
// - select fall starts access, expects header
// - capture on rising, change on falling clock
// - host ends access by raising select
// - bytes of eight bits, MSB first
// - first byte decoded as sequence header
// - headers 00/08 start codec command sequences
// - command followed by 0, 1, 4, 8 bytes
// - any commands, any order, until select rises
// - 40/44 non-interleaved address/data, read or write
// - read data only in slot after address
// - 48/4C read data overlaps next address byte
// - 4A/4E one address, autoincrement per byte
// - 43 address reaches FIFO, pointer advances
// - 41/49 reads until write address, then writes
module scp_device (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	scp_if.device                    port,
	input  wire logic                large_package,
	input  wire logic                strap_write_n,
	input  wire logic                strap_read_n,
	input  wire logic                strap_latch,
	output scp_pkg::host_mode_t      host_mode,
	output logic                     parallel_latch_sel,
	input  wire logic                mon_wr,
	input  wire logic [7:0]          mon_addr,
	input  wire logic [7:0]          mon_data,
	output logic                     reg_wr,
	output logic                     reg_rd,
	output logic [7:0]               reg_addr,
	output logic [7:0]               reg_wdata,
	input  wire logic [7:0]          reg_rdata,
	output logic [5:0]               fifo_ptr,
	output logic                     fifo_access,
	output logic                     cmd_valid,
	output logic                     codec_data_valid,
	output logic [7:0]               codec_byte,
	input  wire logic [7:0]          codec_rdata
);

	typedef enum {
		ST_HDR, ST_ADDR, ST_WDATA, ST_RSLOT, ST_CMD, ST_CDATA, ST_STREAM, ST_IGNORE
	} st_t;
	typedef enum {K_ADAD, K_AUTO, K_FIFO, K_RDFIRST, K_CODEC} kind_t;

	// ***********************
	// pin synchronisers
	// ***********************
	logic [2:0] sclk_s_q;
	logic [2:0] sel_s_q;
	logic [1:0] sdi_s_q;
	logic [1:0] strap_s_q [4];
	logic       strap_done_q;
	logic       serial_on;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       sel_fall;
	logic       sel_high;

	// two flops before use; bit 2 feeds edge detection and the strap capture check
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_s_q <= 3'h7;
			sel_s_q  <= 3'h7;
			sdi_s_q  <= 2'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], port.sclk};
			sel_s_q  <= {sel_s_q[1:0], port.select_n};
			sdi_s_q  <= {sdi_s_q[0], port.serial_data_in};
		end
	end

	// straps keep sampling through reset: a reset value here would be
	// captured as the strap level at the first edge after release
	always_ff @(posedge clk_sys) begin
		strap_s_q[0] <= {strap_s_q[0][0], port.select_n};
		strap_s_q[1] <= {strap_s_q[1][0], strap_write_n};
		strap_s_q[2] <= {strap_s_q[2][0], strap_read_n};
		strap_s_q[3] <= {strap_s_q[3][0], strap_latch};
	end

	assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
	assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
	assign sel_fall  = ~sel_s_q[1] & sel_s_q[2];
	assign sel_high  = sel_s_q[1];
	assign serial_on = strap_done_q && (host_mode == scp_pkg::MODE_SERIAL);

	// ***********************
	// strap decode
	// ***********************
	// one-shot capture: taken at the first edge after release, from levels sampled during reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			strap_done_q       <= 1'b0;
			host_mode          <= scp_pkg::MODE_SERIAL;
			parallel_latch_sel <= 1'b0;
		end else if (!strap_done_q && sel_s_q[2] == sel_s_q[1]) begin
			strap_done_q       <= 1'b1;
			parallel_latch_sel <= strap_s_q[3][1];
			// large package with both strobes high gives the parallel bus
			if (large_package && strap_s_q[1][1] && strap_s_q[2][1]) begin
				host_mode <= scp_pkg::MODE_PARALLEL;
			// select level chooses serial or monitor slave
			end else if (strap_s_q[0][1]) begin
				host_mode <= scp_pkg::MODE_SERIAL;
			end else begin
				host_mode <= scp_pkg::MODE_MONITOR;
			end
		end
	end

	// ***********************
	// bit engine
	// ***********************
	logic [7:0] rx_q;
	logic [2:0] bit_q;
	logic       byte_done_q;
	logic [7:0] byte_q;
	logic [7:0] tx_q;
	logic       armed_q;
	logic       drive_q;
	logic       out_q;
	logic       load_reg_q;
	logic       load_codec_q;

	// capture on rising; MSB first, eight bits; fall restarts count
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_q        <= 8'h00;
			bit_q       <= 3'h0;
			byte_done_q <= 1'b0;
			byte_q      <= 8'h00;
		end else begin
			byte_done_q <= 1'b0;
			if (sel_fall || sel_high) begin
				bit_q <= 3'h0;
			end else if (sclk_rise && serial_on) begin
				rx_q  <= {rx_q[6:0], sdi_s_q[1]};
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					byte_done_q <= 1'b1;
					byte_q      <= {rx_q[6:0], sdi_s_q[1]};
				end
			end
		end
	end

	// change on falling; drive only in the armed slot
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_q    <= 8'h00;
			armed_q <= 1'b0;
			drive_q <= 1'b0;
			out_q   <= 1'b1;
		end else if (sel_high) begin
			armed_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (load_reg_q || load_codec_q) begin
			tx_q    <= load_reg_q ? reg_rdata : codec_rdata;
			armed_q <= 1'b1;
		end else if (byte_done_q) begin
			armed_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (sclk_fall && armed_q) begin
			drive_q <= 1'b1;
			out_q   <= tx_q[7];
			tx_q    <= {tx_q[6:0], 1'b0};
		end
	end

	// data out line is the only pin the device drives
	assign port.serial_data_out_o  = out_q;
	assign port.serial_data_out_oe = drive_q;

	// ***********************
	// byte sequencer
	// ***********************
	st_t        state_q;
	kind_t      kind_q;
	logic       inter_q;
	logic       coef_q;
	logic       rd_stream_q;
	logic [3:0] cnt_q;
	logic [7:0] addr_q;
	logic [7:0] a_byte;
	logic       a_rd;
	logic       rd_now;
	logic       wr_now;
	logic [7:0] acc_addr;

	function automatic logic [3:0] cmd_len(input logic [7:0] c);
		case (c[1:0])
			2'h0:    cmd_len = scp_pkg::CMD_LEN0;
			2'h1:    cmd_len = scp_pkg::CMD_LEN1;
			2'h2:    cmd_len = scp_pkg::CMD_LEN2;
			default: cmd_len = scp_pkg::CMD_LEN3;
		endcase
	endfunction : cmd_len

	assign a_byte = {coef_q ? scp_pkg::COEF_BASE_BIT : 1'b0, byte_q[6:0]};
	assign a_rd   = byte_q[scp_pkg::ADDR_RD_BIT];

	// access decision for the byte just completed
	always_comb begin
		rd_now   = 1'b0;
		wr_now   = 1'b0;
		acc_addr = addr_q;
		if (byte_done_q) begin
			case (state_q)
				ST_ADDR: begin
					acc_addr = a_byte;
					rd_now   = a_rd;
				end
				ST_WDATA: wr_now = 1'b1;
				ST_STREAM: begin
					// another read follows each read slot: next address for auto, same address for fifo
					if (rd_stream_q) begin
						acc_addr = (kind_q == K_AUTO) ? addr_q + 8'h01 : addr_q;
						rd_now   = 1'b1;
					end else begin
						wr_now = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// header decode; select high ends any sequence
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q     <= ST_HDR;
			kind_q      <= K_ADAD;
			inter_q     <= 1'b0;
			coef_q      <= 1'b0;
			rd_stream_q <= 1'b0;
			cnt_q       <= 4'h0;
			addr_q      <= 8'h00;
		end else if (sel_high || sel_fall) begin
			state_q <= ST_HDR;
		end else if (byte_done_q) begin
			case (state_q)
				ST_HDR: begin
					state_q <= ST_ADDR;
					inter_q <= 1'b0;
					coef_q  <= 1'b0;
					case (byte_q)
						scp_pkg::HDR_CODEC_NI: begin
							kind_q  <= K_CODEC;
							state_q <= ST_CMD;
						end
						scp_pkg::HDR_CODEC_IL: begin
							kind_q  <= K_CODEC;
							inter_q <= 1'b1;
							state_q <= ST_CMD;
						end
						scp_pkg::HDR_ADAD_NI:   kind_q <= K_ADAD;
						scp_pkg::HDR_ADAD_NI_C: begin
							kind_q <= K_ADAD;
							coef_q <= 1'b1;
						end
						scp_pkg::HDR_ADAD_IL: begin
							kind_q  <= K_ADAD;
							inter_q <= 1'b1;
						end
						scp_pkg::HDR_ADAD_IL_C: begin
							kind_q  <= K_ADAD;
							inter_q <= 1'b1;
							coef_q  <= 1'b1;
						end
						scp_pkg::HDR_AUTO:   kind_q <= K_AUTO;
						scp_pkg::HDR_AUTO_C: begin
							kind_q <= K_AUTO;
							coef_q <= 1'b1;
						end
						scp_pkg::HDR_FIFO:    kind_q <= K_FIFO;
						scp_pkg::HDR_RDWR_NI: kind_q <= K_RDFIRST;
						scp_pkg::HDR_RDWR_IL: begin
							kind_q  <= K_RDFIRST;
							inter_q <= 1'b1;
						end
						default: state_q <= ST_IGNORE;
					endcase
				end
				ST_ADDR: begin
					addr_q <= a_byte;
					if (kind_q == K_AUTO || kind_q == K_FIFO) begin
						rd_stream_q <= a_rd;
						state_q     <= ST_STREAM;
					// write address ends the read phase
					end else if (kind_q == K_RDFIRST && !a_rd) begin
						rd_stream_q <= 1'b0;
						state_q     <= ST_STREAM;
					end else if (a_rd) begin
						state_q <= inter_q ? ST_ADDR : ST_RSLOT;
					end else begin
						state_q <= ST_WDATA;
					end
				end
				ST_WDATA: state_q <= ST_ADDR;
				ST_RSLOT: state_q <= ST_ADDR;
				ST_STREAM: begin
					if (kind_q == K_AUTO) begin
						addr_q <= addr_q + 8'h01;
					end
				end
				// data count fixed by the command
				ST_CMD: begin
					cnt_q <= cmd_len(byte_q);
					if (cmd_len(byte_q) != 4'h0) begin
						state_q <= ST_CDATA;
					end
				end
				// back to commands, any number of them
				ST_CDATA: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						state_q <= ST_CMD;
					end
				end
				default: ;
			endcase
		end
	end

	// ***********************
	// register and codec side
	// ***********************
	// monitor writes take the register port only in monitor mode
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_wr     <= 1'b0;
			reg_rd     <= 1'b0;
			reg_addr   <= 8'h00;
			reg_wdata  <= 8'h00;
			load_reg_q <= 1'b0;
		end else begin
			load_reg_q <= reg_rd;
			reg_rd     <= rd_now;
			reg_wr     <= wr_now;
			if (rd_now || wr_now) begin
				reg_addr  <= acc_addr;
				reg_wdata <= byte_q;
			end else if (strap_done_q && host_mode == scp_pkg::MODE_MONITOR && mon_wr) begin
				reg_wr    <= 1'b1;
				reg_addr  <= mon_addr;
				reg_wdata <= mon_data;
			end
		end
	end

	// pointer steps with every data byte of a fifo stream
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fifo_ptr    <= 6'h00;
			fifo_access <= 1'b0;
		end else begin
			fifo_access <= (kind_q == K_FIFO) && (rd_now || wr_now);
			if (byte_done_q && state_q == ST_STREAM && kind_q == K_FIFO) begin
				fifo_ptr <= fifo_ptr + 6'h01;
			end
		end
	end

	// codec bytes out; interleaved mode returns codec data meanwhile
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_valid        <= 1'b0;
			codec_data_valid <= 1'b0;
			codec_byte       <= 8'h00;
			load_codec_q     <= 1'b0;
		end else begin
			cmd_valid        <= byte_done_q && state_q == ST_CMD;
			codec_data_valid <= byte_done_q && state_q == ST_CDATA;
			load_codec_q     <= byte_done_q && inter_q && kind_q == K_CODEC
				&& ((state_q == ST_CMD && cmd_len(byte_q) != 4'h0)
				|| (state_q == ST_CDATA && cnt_q != 4'h1));
			if (byte_done_q) begin
				codec_byte <= byte_q;
			end
		end
	end

endmodule : scp_device

// [core/scp_host.sv]
// host end: serial bus master with clock divider
`timescale 1ns/1ns
module scp_host #(
	parameter int HALF = scp_pkg::SCLK_HALF_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	scp_if.host             port,
	input  wire logic       req_valid,
	input  wire logic [7:0] req_byte,
	input  wire logic       req_last,
	output logic            req_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_byte,
	output logic            busy
);

	typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_WAIT, H_TAIL} hst_t;

	hst_t       state_q;
	logic [7:0] div_q;
	logic [2:0] bit_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic       last_q;
	logic       sclk_q;
	logic       sel_q;
	logic       sdo_q;
	logic [1:0] sdi_s_q;
	logic       div_end;

	assign div_end   = (div_q == 8'(HALF - 1));
	assign req_ready = (state_q == H_IDLE || state_q == H_WAIT) && req_valid;
	assign busy      = (state_q != H_IDLE);

	// host drives clock, select and data in
	assign port.sclk           = sclk_q;
	assign port.select_n       = sel_q;
	assign port.serial_data_in = sdo_q;

	// returned data passes two flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sdi_s_q <= 2'h3;
		end else begin
			sdi_s_q <= {sdi_s_q[0], port.serial_data_out};
		end
	end

	// ***********************
	// master sequencer
	// ***********************
	// sampling waits to the end of the high phase to cover synchroniser lag
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q   <= H_IDLE;
			div_q     <= 8'h00;
			bit_q     <= 3'h0;
			tx_q      <= 8'h00;
			rx_q      <= 8'h00;
			last_q    <= 1'b0;
			sclk_q    <= 1'b1;
			sel_q     <= 1'b1;
			sdo_q     <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_byte  <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			div_q     <= div_end ? 8'h00 : div_q + 8'h01;
			case (state_q)
				// select falls to open an access
				H_IDLE: begin
					div_q <= 8'h00;
					if (req_valid) begin
						sel_q   <= 1'b0;
						tx_q    <= req_byte;
						last_q  <= req_last;
						state_q <= H_LEAD;
					end
				end
				H_LEAD: if (div_end) begin
					state_q <= H_LOW;
					sclk_q  <= 1'b0;
					sdo_q   <= tx_q[7];
					tx_q    <= {tx_q[6:0], 1'b0};
				end
				H_LOW: if (div_end) begin
					state_q <= H_HIGH;
					sclk_q  <= 1'b1;
				end
				// eight bits, MSB first, both directions
				H_HIGH: if (div_end) begin
					rx_q  <= {rx_q[6:0], sdi_s_q[1]};
					bit_q <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						rsp_valid <= 1'b1;
						rsp_byte  <= {rx_q[6:0], sdi_s_q[1]};
						state_q   <= last_q ? H_TAIL : H_WAIT;
					end else begin
						state_q <= H_LOW;
						sclk_q  <= 1'b0;
						sdo_q   <= tx_q[7];
						tx_q    <= {tx_q[6:0], 1'b0};
					end
				end
				// change data with the falling clock
				H_WAIT: begin
					div_q <= 8'h00;
					if (req_valid) begin
						last_q  <= req_last;
						state_q <= H_LOW;
						sclk_q  <= 1'b0;
						sdo_q   <= req_byte[7];
						tx_q    <= {req_byte[6:0], 1'b0};
					end
				end
				// select rises to end the access
				H_TAIL: if (div_end) begin
					sel_q   <= 1'b1;
					sdo_q   <= 1'b1;
					state_q <= H_IDLE;
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

endmodule : scp_host

// [tb/scp_chk.sv]
// assertions on the four wires between host end and device end
`timescale 1ns/1ns
module scp_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic serial_data_in,
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe,
	input wire logic serial_data_out
);
	logic       sclk_q;
	logic [7:0] rise_cnt_q;

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ********
	// helper count
	// ********
	// serial rising edges since select fell; checks use the count mod 8 and whether it passed zero or eight
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_q     <= 1'b1;
			rise_cnt_q <= 8'h00;
		end else begin
			sclk_q <= sclk;
			if (select_n) begin
				rise_cnt_q <= 8'h00;
			end else if (sclk && !sclk_q) begin
				rise_cnt_q <= rise_cnt_q + 8'h01;
			end
		end
	end

	// ********
	// wire rules
	// ********
	a_idle_clock_high: assert property (select_n |-> sclk)
		else $error("serial clock low while select high");
	a_sel_release_oe: assert property (select_n [*5] |-> !serial_data_out_oe && serial_data_out)
		else $error("data out still driven after select rose");
	a_in_stable_rise: assert property ($rose(sclk) && !select_n |-> $stable(serial_data_in))
		else $error("data in moved on rising clock");
	a_out_stable_rise: assert property ($rose(sclk) && serial_data_out_oe |-> $stable(serial_data_out_o))
		else $error("data out moved on rising clock");
	a_out_after_fall: assert property ($changed(serial_data_out_o) && serial_data_out_oe
		&& $past(serial_data_out_oe) |-> !$past(sclk, 3))
		else $error("data out changed away from a falling clock");
	a_clock_low_half: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
		else $error("serial clock low phase wrong length");
	a_whole_bytes: assert property ($rose(select_n) |-> rise_cnt_q[2:0] == 3'h0 && rise_cnt_q != 8'h00)
		else $error("frame not whole bytes");
	a_oe_slot_start: assert property ($rose(serial_data_out_oe) |-> rise_cnt_q[2:0] == 3'h0
		&& rise_cnt_q >= 8'h08)
		else $error("data out driven off a byte boundary");
	a_oe_slot_end: assert property ($fell(serial_data_out_oe) |-> rise_cnt_q[2:0] == 3'h0)
		else $error("data out released mid byte");

	c_read_slot: cover property ($rose(serial_data_out_oe));
	c_frame_end: cover property ($rose(select_n));
	c_frame: cover property ($fell(select_n) ##[1:900] $rose(select_n));
endmodule : scp_chk

// [tb/tb.sv]
// self-checking bench: host end and device end joined by the port interface
`timescale 1ns/1ns
module tb;
	typedef struct {
		logic [79:0] b;
		int          n;
		int          s;
		logic [7:0]  e;
		int          nc;
		int          nd;
	} row_t;

	logic                clk_sys       = 1'b0;
	logic                rst           = 1'b1;
	logic                large_package = 1'b0;
	logic                strap_write_n = 1'b0;
	logic                strap_read_n  = 1'b0;
	logic                strap_latch   = 1'b0;
	logic                mon_wr        = 1'b0;
	logic [7:0]          mon_addr      = 8'h00;
	logic [7:0]          mon_data      = 8'h00;
	logic [7:0]          reg_rdata     = 8'h00;
	logic [7:0]          codec_rdata   = 8'h3c;
	logic                req_valid     = 1'b0;
	logic [7:0]          req_byte      = 8'h00;
	logic                req_last      = 1'b0;
	scp_pkg::host_mode_t host_mode;
	logic                parallel_latch_sel;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic [5:0]          fifo_ptr;
	logic [5:0]          fifo_start;
	logic                fifo_access;
	logic                cmd_valid;
	logic                codec_data_valid;
	logic [7:0]          codec_byte;
	logic                req_ready;
	logic                rsp_valid;
	logic [7:0]          rsp_byte;
	logic                busy;
	logic [7:0]          mem [256]     = '{default: 8'h00};
	logic [7:0]          rsp [$];
	int                  n_cmd;
	int                  n_cd;
	int                  n_fa;
	logic [7:0]          last_cd;
	int                  n_mismatch;
	int                  checked;
	int                  cycles;

	// frame bytes (right aligned), count, checked slot, byte seen there, codec counts
	row_t rows [17] = '{
		'{80'h4005a78500, 5, 4, 8'ha7, 0, 0}, '{80'h44123c9200, 5, 4, 8'h3c, 0, 0},
		'{80'h4806c48607, 5, 4, 8'hc4, 0, 0}, '{80'h4c13e19300, 5, 4, 8'he1, 0, 0},
		'{80'h4a20112233, 5, 4, 8'hff, 0, 0}, '{80'h4aa0000000, 5, 4, 8'h33, 0, 0},
		'{80'h4e307788, 4, 3, 8'hff, 0, 0}, '{80'h4eb00000, 4, 3, 8'h88, 0, 0},
		'{80'h418500065d5e, 6, 2, 8'ha7, 0, 0}, '{80'h408600, 3, 2, 8'h5e, 0, 0},
		'{80'h49850655, 4, 2, 8'ha7, 0, 0}, '{80'h408600, 3, 2, 8'h55, 0, 0},
		'{80'h43850000, 4, 3, 8'ha7, 0, 0}, '{80'h0002d1d2d3d401e100, 9, 8, 8'hff, 3, 5},
		'{80'h0803a1a2a3a4a5a6a7a8, 10, 2, 8'h3c, 1, 8},
		'{80'h4f05998500, 5, 4, 8'hff, 0, 0}, '{80'h408500, 3, 2, 8'ha7, 0, 0}};

	scp_if u_scp_if ();

	scp_device u_scp_device (
		.clk_sys(clk_sys), .rst(rst), .port(u_scp_if.device),
		.large_package(large_package), .strap_write_n(strap_write_n),
		.strap_read_n(strap_read_n), .strap_latch(strap_latch), .host_mode(host_mode),
		.parallel_latch_sel(parallel_latch_sel), .mon_wr(mon_wr), .mon_addr(mon_addr),
		.mon_data(mon_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_ptr(fifo_ptr),
		.fifo_access(fifo_access), .cmd_valid(cmd_valid), .codec_data_valid(codec_data_valid),
		.codec_byte(codec_byte), .codec_rdata(codec_rdata)
	);

	scp_host #(.HALF(4)) u_scp_host (
		.clk_sys(clk_sys), .rst(rst), .port(u_scp_if.host), .req_valid(req_valid),
		.req_byte(req_byte), .req_last(req_last), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .busy(busy)
	);

	scp_chk u_scp_chk (
		.clk_sys(clk_sys), .rst(rst), .sclk(u_scp_if.sclk), .select_n(u_scp_if.select_n),
		.serial_data_in(u_scp_if.serial_data_in), .serial_data_out_o(u_scp_if.serial_data_out_o),
		.serial_data_out_oe(u_scp_if.serial_data_out_oe), .serial_data_out(u_scp_if.serial_data_out)
	);

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	// register file behind the device; read data lands the cycle after the strobe
	always @(posedge clk_sys) begin
		if (reg_wr === 1'b1) begin
			mem[reg_addr] <= reg_wdata;
		end
		if (reg_rd === 1'b1) begin
			reg_rdata <= mem[reg_addr];
		end
		if (cmd_valid === 1'b1) begin
			n_cmd++;
		end
		if (codec_data_valid === 1'b1) begin
			n_cd++;
			last_cd <= codec_byte;
		end
		if (fifo_access === 1'b1) begin
			n_fa++;
		end
		if (rsp_valid === 1'b1) begin
			rsp.push_back(rsp_byte);
		end
	end

	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 15000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	// straps held from before release on; first frame well after the first edge
	task automatic do_reset(input logic [3:0] st);
		rst <= 1'b1;
		{large_package, strap_write_n, strap_read_n, strap_latch} <= st;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask : do_reset

	// request held until taken, next byte follows at once so the host never idles
	task automatic frame(input logic [7:0] q[$]);
		rsp.delete();
		n_cmd = 0;
		n_cd = 0;
		n_fa = 0;
		for (int i = 0; i < q.size(); i++) begin
			req_valid <= 1'b1;
			req_byte  <= q[i];
			req_last  <= (i == q.size() - 1);
			do @(posedge clk_sys); while (req_ready !== 1'b1);
		end
		req_valid <= 1'b0;
		do @(posedge clk_sys); while (busy !== 1'b0);
	endtask : frame

	task automatic run_row(input row_t r);
		logic [7:0] q[$];
		for (int i = 0; i < r.n; i++) begin
			q.push_back(r.b[8 * (r.n - 1 - i) +: 8]);
		end
		frame(q);
	endtask : run_row

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// ********
	// sequence
	// ********
	initial begin
		do_reset(4'h0);
		check("mode", {6'h00, host_mode}, {6'h00, scp_pkg::MODE_SERIAL});
		for (int i = 0; i < 17; i++) begin
			run_row(rows[i]);
			check("slot byte", rows[i].e, rsp[rows[i].s]);
			check("commands", 8'(rows[i].nc), 8'(n_cmd));
			check("codec bytes", 8'(rows[i].nd), 8'(n_cd));
			$display("row %0d done", i);
		end
		check("codec byte", 8'ha8, last_cd);
		// fifo pointer steps per data byte while the address stays put
		fifo_start = fifo_ptr;
		run_row('{80'h4305a1a2a3, 5, 0, 8'h00, 0, 0});
		check("fifo pointer", {2'h0, fifo_ptr}, {2'h0, fifo_start + 6'h03});
		check("fifo strobes", 8'h03, 8'(n_fa));
		// monitor writes must be ignored while the serial port is chosen
		mon_addr <= 8'h05;
		mon_data <= 8'h66;
		mon_wr   <= 1'b1;
		@(posedge clk_sys);
		mon_wr <= 1'b0;
		run_row('{80'h408500, 3, 0, 8'h00, 0, 0});
		check("fifo data", 8'ha3, rsp[2]);
		$display("fifo test done");
		// reset lands mid-frame, then the parallel bus is strapped
		req_valid <= 1'b1;
		req_byte  <= 8'h40;
		req_last  <= 1'b0;
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		repeat (40) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check("enable in reset", 8'h00, {7'h00, u_scp_if.serial_data_out_oe});
		do_reset(4'hf);
		check("mode", {6'h00, host_mode}, {6'h00, scp_pkg::MODE_PARALLEL});
		check("latch strap", 8'h01, {7'h00, parallel_latch_sel});
		run_row('{80'h408500, 3, 0, 8'h00, 0, 0});
		check("parallel link idle", 8'hff, rsp[2]);
		do_reset(4'h8);
		check("mode", {6'h00, host_mode}, {6'h00, scp_pkg::MODE_SERIAL});
		run_row('{80'h408500, 3, 0, 8'h00, 0, 0});
		check("serial again", 8'ha3, rsp[2]);
		$display("reset test done");
		end_of_test();
	end
endmodule : tb
